//--- src/vpi_pkg.sv
// Constants, register map and types of the video preamp serial control block
//
// Function
// RL1 - Brightness register sets common offset added after contrast while blanking inactive.
// RL2 - Three 8-bit drive registers set each channel's overall gain.
// RL3 - Drive gain follows contrast, brightness and overlay, scaling overlay too.
// RL4 - Fast blank high: inputs go to clamp reference, outputs follow overlay bits.
// RL5 - Overlay bit low gives brightness level, high gives brightness plus overlay level.
// RL6 - 4-bit overlay level register applies one increment to all channels.
// RL7 - Pattern red=1 green=0 blue=1 with grey bits selects light or dark grey.
// RL8 - Blanking active forces all outputs to infra-black, overriding brightness.
// RL9 - Infra-black sampled by pulse inside blanking; target from common or per-channel.
// RL10 - Clamp config bit 7 routes internal clamp pulse to the sample-and-hold.
// RL11 - Host sets brightness to zero when the internal clamp pulse drives sampling.
// RL12 - Common 4-bit level and three 8-bit per-channel cut-off registers.
// RL13 - Plain DC coupling: host sets mode bit 2 and clears bit 3.
// RL14 - AC or cut-off-control coupling: host sets mode bits 2, 3 and 4.
// RL15 - Feedback coupling: host clears mode bits 2 and 4.
// RL16 - Standby shuts analog off while serial interface and registers keep working.
// RL17 - Respond only to 7-bit slave address 1101110 with write bit.
// RL18 - Write-only interface; no register readback is ever driven.
// RL19 - Write is start, address byte, register byte, data byte, stop, MSB first.
// RL20 - Further register and data pairs follow within one transfer and are accepted.
// RL21 - Power-on reset puts every control register in a defined default.
// RL22 - Clamp config bits select source, sync edge, width and direct external pulse.
// RL23 - Mode bit 0 sets blanking polarity, bit 7 enables green sync clipping.
// RL24 - Acknowledge each accepted byte in ninth clock; latch data after full byte.
// RL25 - Writes to unimplemented addresses are acknowledged and ignored.
package vpi_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h6e;
  localparam int         NUM_REGS        = 13;
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h02;
  localparam logic [7:0] ADDR_DRIVE_RED  = 8'h03;
  localparam logic [7:0] ADDR_DRIVE_GRN  = 8'h04;
  localparam logic [7:0] ADDR_DRIVE_BLU  = 8'h05;
  localparam logic [7:0] ADDR_COMMON_DC  = 8'h06;
  localparam logic [7:0] ADDR_OSD_LEVEL  = 8'h07;
  localparam logic [7:0] ADDR_CLAMP_CFG  = 8'h08;
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h09;
  localparam logic [7:0] ADDR_LEVEL_RED  = 8'h0a;
  localparam logic [7:0] ADDR_LEVEL_GRN  = 8'h0b;
  localparam logic [7:0] ADDR_LEVEL_BLU  = 8'h0c;
  localparam logic [7:0] MASK_NIBBLE     = 8'h0f;
  localparam logic [7:0] RST_DRIVE       = 8'hb4;
  localparam logic [7:0] RST_OTHER       = 8'h00;
  localparam int CLAMP_SRC_BLANK_BIT = 0;
  localparam int CLAMP_EDGE_BIT      = 1;
  localparam int CLAMP_WIDTH_LSB     = 2;
  localparam int CLAMP_DIRECT_BIT    = 4;
  localparam int CLAMP_TO_SAMPLE_BIT = 7;
  localparam int MODE_BLANK_POL_BIT  = 0;
  localparam int MODE_COUPLE_A_BIT   = 2;
  localparam int MODE_COUPLE_B_BIT   = 3;
  localparam int MODE_COUPLE_C_BIT   = 4;
  localparam int MODE_LIGHT_GREY_BIT = 5;
  localparam int MODE_DARK_GREY_BIT  = 6;
  localparam int MODE_SYNC_CLIP_BIT  = 7;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SAMPLE_DELAY_NS  = 300;
  localparam int SAMPLE_WIDTH_NS  = 500;
  localparam int CLAMP_W0_NS      = 300;
  localparam int CLAMP_W1_NS      = 500;
  localparam int CLAMP_W2_NS      = 700;
  localparam int CLAMP_W3_NS      = 900;
  localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_WIDTH_CYC = (SAMPLE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_W0_CYC     = (CLAMP_W0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_W1_CYC     = (CLAMP_W1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_W2_CYC     = (CLAMP_W2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLAMP_W3_CYC     = (CLAMP_W3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ACK_ADDR  = 3'b010,
    ST_REG       = 3'b011,
    ST_ACK_REG   = 3'b100,
    ST_DATA      = 3'b101,
    ST_ACK_DATA  = 3'b110,
    ST_SKIP      = 3'b111
  } vpi_state_type;
  typedef enum logic [2:0] {
    SRC_VIDEO    = 3'b000,
    SRC_BRIGHT   = 3'b001,
    SRC_OSD      = 3'b010,
    SRC_LIGHT    = 3'b011,
    SRC_DARK     = 3'b100,
    SRC_INFRA    = 3'b101
  } vpi_src_type;
endpackage

//--- src/vpi_control.sv
// Serial write slave, control registers and output source selection of the preamp
`timescale 1ns/100ps
`default_nettype none
module vpi_control
  import vpi_pkg::*;
(
  // Clock and reset
  input  wire logic       REF_CLK_I,
  input  wire logic       RSTN_I,
  // Serial bus
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O,
  // Video timing and overlay pins
  input  wire logic       FAST_BLANK_IN_I,
  input  wire logic       BLANK_IN_I,
  input  wire logic       OVERLAY_RED_IN_I,
  input  wire logic       OVERLAY_GREEN_IN_I,
  input  wire logic       OVERLAY_BLUE_IN_I,
  input  wire logic       HSYNC_I,
  input  wire logic       POWER_LOW_I,
  // Output source per channel
  output vpi_src_type     SRC_RED_O,
  output vpi_src_type     SRC_GREEN_O,
  output vpi_src_type     SRC_BLUE_O,
  output logic            INPUT_TO_CLAMP_O,
  // Infra-black targets
  output logic [7:0]      TARGET_RED_O,
  output logic [7:0]      TARGET_GREEN_O,
  output logic [7:0]      TARGET_BLUE_O,
  output logic            COMMON_TARGET_O,
  // Pulses
  output logic            BACK_PORCH_CLAMP_PULSE_O,
  output logic            LEVEL_SAMPLE_PULSE_O,
  // Register values to the analog side
  output logic [7:0]      BRIGHTNESS_SETTING_O,
  output logic [7:0]      DRIVE_RED_O,
  output logic [7:0]      DRIVE_GREEN_O,
  output logic [7:0]      DRIVE_BLUE_O,
  output logic [3:0]      COMMON_DC_O,
  output logic [3:0]      OSD_LEVEL_O,
  output logic [7:0]      LEVEL_RED_O,
  output logic [7:0]      LEVEL_GREEN_O,
  output logic [7:0]      LEVEL_BLUE_O,
  output logic            SYNC_CLIP_O,
  output logic            ANALOG_ON_O
);

  // Register file helpers
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a >= ADDR_BRIGHTNESS) && (a <= ADDR_LEVEL_BLU);
  endfunction

  function automatic logic [7:0] reg_mask(input logic [7:0] a);
    reg_mask = ((a == ADDR_COMMON_DC) || (a == ADDR_OSD_LEVEL)) ? MASK_NIBBLE : 8'hff;
  endfunction

  function automatic logic [7:0] reg_reset(input int i);
    reg_reset = ((i >= int'(ADDR_DRIVE_RED)) && (i <= int'(ADDR_DRIVE_BLU))) ? RST_DRIVE : RST_OTHER;
  endfunction

  // Overlay and blanking mux for one channel
  function automatic vpi_src_type pick_src(input logic blank, input logic fast, input logic bit_in,
                                           input logic grey, input logic light, input logic dark);
    if (blank) begin
      pick_src = SRC_INFRA;
    end else if (fast && grey && light) begin
      pick_src = SRC_LIGHT;
    end else if (fast && grey && dark) begin
      pick_src = SRC_DARK;
    end else if (fast) begin
      pick_src = bit_in ? SRC_OSD : SRC_BRIGHT;
    end else begin
      pick_src = SRC_VIDEO;
    end
  endfunction

  function automatic logic [3:0] clamp_width(input logic [1:0] sel);
    case (sel)
      2'h0:    clamp_width = 4'(CLAMP_W0_CYC);
      2'h1:    clamp_width = 4'(CLAMP_W1_CYC);
      2'h2:    clamp_width = 4'(CLAMP_W2_CYC);
      default: clamp_width = 4'(CLAMP_W3_CYC);
    endcase
  endfunction

  // Input synchronisers; every pin is asynchronous to the reference clock
  logic [8:0]        meta_r;
  logic [8:0]        sync_r;
  logic [8:0]        sync_d_r;
  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic              blank_act;
  logic              blank_rise;
  logic              hs_rise;
  logic              hs_fall;
  vpi_state_type     state_r;
  logic [3:0]        bit_cnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        reg_addr_r;
  logic [NUM_REGS-1:0][7:0] cfg_r;
  logic              byte_done;
  logic              addr_match;
  logic              wr_en;
  logic [3:0]        cp_cnt_r;
  logic [3:0]        sp_cnt_r;
  logic              clamp_nxt;
  logic              sample_nxt;
  logic              grey_pat;
  logic              ac_mode;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      meta_r   <= 9'h003;
      sync_r   <= 9'h003;
      sync_d_r <= 9'h003;
    end else begin
      meta_r   <= {POWER_LOW_I, HSYNC_I, BLANK_IN_I, FAST_BLANK_IN_I, OVERLAY_BLUE_IN_I,
                   OVERLAY_GREEN_IN_I, OVERLAY_RED_IN_I, SDA_I, SCL_I};
      sync_r   <= meta_r;
      sync_d_r <= sync_r;
    end
  end

  assign scl_s      = sync_r[0];
  assign sda_s      = sync_r[1];
  assign scl_rise   = scl_s && !sync_d_r[0];
  assign scl_fall   = !scl_s && sync_d_r[0];
  assign start_cond = scl_s && sync_d_r[0] && !sda_s && sync_d_r[1];
  assign stop_cond  = scl_s && sync_d_r[0] && sda_s && !sync_d_r[1];
  assign blank_act  = sync_r[6] ^ cfg_r[ADDR_MODE_CTRL][MODE_BLANK_POL_BIT]; // RL23
  assign blank_rise = blank_act && !(sync_d_r[6] ^ cfg_r[ADDR_MODE_CTRL][MODE_BLANK_POL_BIT]);
  assign hs_rise    = sync_r[7] && !sync_d_r[7];
  assign hs_fall    = !sync_r[7] && sync_d_r[7];
  assign byte_done  = scl_fall && (bit_cnt_r == 4'h8);
  assign addr_match = (shift_r[7:1] == SLAVE_ADDR) && !shift_r[0]; // RL17
  assign wr_en      = byte_done && (state_r == ST_DATA) && reg_known(reg_addr_r);

  // Serial protocol state
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      reg_addr_r <= 8'h00;
      SDA_OE_O   <= 1'b0;
    end else if (start_cond) begin
      state_r   <= ST_ADDR; // RL19
      bit_cnt_r <= 4'h0;
      SDA_OE_O  <= 1'b0;
    end else if (stop_cond) begin
      state_r  <= ST_IDLE;
      SDA_OE_O <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_REG, ST_DATA: begin
          if (scl_rise && (bit_cnt_r != 4'h8)) begin
            shift_r   <= {shift_r[6:0], sda_s}; // RL19
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (byte_done) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_ADDR) begin
              state_r  <= addr_match ? ST_ACK_ADDR : ST_SKIP;
              SDA_OE_O <= addr_match; // RL24
            end else if (state_r == ST_REG) begin
              reg_addr_r <= shift_r;
              state_r    <= ST_ACK_REG;
              SDA_OE_O   <= 1'b1; // RL24
            end else begin
              state_r  <= ST_ACK_DATA;
              SDA_OE_O <= 1'b1; // RL25
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA: begin
          if (scl_fall) begin
            SDA_OE_O <= 1'b0;
            if (state_r == ST_ACK_REG) begin
              state_r <= ST_DATA;
            end else begin
              state_r <= ST_REG; // RL20
            end
          end
        end
        ST_IDLE, ST_SKIP: begin
          SDA_OE_O <= 1'b0;
        end
        default: begin
          state_r  <= ST_IDLE;
          SDA_OE_O <= 1'b0;
        end
      endcase
    end
  end

  // Pin only ever pulls low; no read path exists
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0; // RL18
    end
  end

  // Control registers, written only once the whole data byte is in
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_r[i] <= reg_reset(i); // RL21
      end
    end else if (wr_en) begin
      cfg_r[reg_addr_r[3:0]] <= shift_r & reg_mask(reg_addr_r); // RL24
    end
  end

  // Register values toward the analog blocks
  assign BRIGHTNESS_SETTING_O = cfg_r[ADDR_BRIGHTNESS]; // RL1
  assign DRIVE_RED_O          = cfg_r[ADDR_DRIVE_RED]; // RL2
  assign DRIVE_GREEN_O        = cfg_r[ADDR_DRIVE_GRN];
  assign DRIVE_BLUE_O         = cfg_r[ADDR_DRIVE_BLU];
  assign COMMON_DC_O          = cfg_r[ADDR_COMMON_DC][3:0]; // RL12
  assign OSD_LEVEL_O          = cfg_r[ADDR_OSD_LEVEL][3:0]; // RL6
  assign LEVEL_RED_O          = cfg_r[ADDR_LEVEL_RED];
  assign LEVEL_GREEN_O        = cfg_r[ADDR_LEVEL_GRN];
  assign LEVEL_BLUE_O         = cfg_r[ADDR_LEVEL_BLU];
  assign SYNC_CLIP_O          = cfg_r[ADDR_MODE_CTRL][MODE_SYNC_CLIP_BIT]; // RL23

  // Output source select; drive gain sits after this mux on every source
  assign grey_pat = sync_r[2] && !sync_r[3] && sync_r[4];
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SRC_RED_O        <= SRC_VIDEO;
      SRC_GREEN_O      <= SRC_VIDEO;
      SRC_BLUE_O       <= SRC_VIDEO;
      INPUT_TO_CLAMP_O <= 1'b0;
    end else begin
      SRC_RED_O   <= pick_src(blank_act, sync_r[5], sync_r[2], grey_pat, // RL4 RL5 RL8 RL3
                              cfg_r[ADDR_MODE_CTRL][MODE_LIGHT_GREY_BIT], cfg_r[ADDR_MODE_CTRL][MODE_DARK_GREY_BIT]);
      SRC_GREEN_O <= pick_src(blank_act, sync_r[5], sync_r[3], grey_pat, // RL7
                              cfg_r[ADDR_MODE_CTRL][MODE_LIGHT_GREY_BIT], cfg_r[ADDR_MODE_CTRL][MODE_DARK_GREY_BIT]);
      SRC_BLUE_O  <= pick_src(blank_act, sync_r[5], sync_r[4], grey_pat,
                              cfg_r[ADDR_MODE_CTRL][MODE_LIGHT_GREY_BIT], cfg_r[ADDR_MODE_CTRL][MODE_DARK_GREY_BIT]);
      INPUT_TO_CLAMP_O <= sync_r[5]; // RL4
    end
  end

  // Infra-black target: common level only with all three coupling bits set
  assign ac_mode = cfg_r[ADDR_MODE_CTRL][MODE_COUPLE_A_BIT] && cfg_r[ADDR_MODE_CTRL][MODE_COUPLE_B_BIT]
                   && cfg_r[ADDR_MODE_CTRL][MODE_COUPLE_C_BIT]; // RL14
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TARGET_RED_O    <= 8'h00;
      TARGET_GREEN_O  <= 8'h00;
      TARGET_BLUE_O   <= 8'h00;
      COMMON_TARGET_O <= 1'b0;
    end else begin
      TARGET_RED_O    <= ac_mode ? cfg_r[ADDR_COMMON_DC] : cfg_r[ADDR_LEVEL_RED]; // RL9 RL13 RL15
      TARGET_GREEN_O  <= ac_mode ? cfg_r[ADDR_COMMON_DC] : cfg_r[ADDR_LEVEL_GRN];
      TARGET_BLUE_O   <= ac_mode ? cfg_r[ADDR_COMMON_DC] : cfg_r[ADDR_LEVEL_BLU];
      COMMON_TARGET_O <= ac_mode;
    end
  end

  // Back porch clamp pulse; sync assumed positive, so leading edge is the rise
  always_comb begin
    clamp_nxt = 1'b0;
    if (cfg_r[ADDR_CLAMP_CFG][CLAMP_DIRECT_BIT]) begin
      clamp_nxt = sync_r[7]; // RL22
    end else begin
      clamp_nxt = (cp_cnt_r != 4'h0);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cp_cnt_r <= 4'h0;
    end else if (cfg_r[ADDR_CLAMP_CFG][CLAMP_SRC_BLANK_BIT] ? blank_rise // RL22
                 : (cfg_r[ADDR_CLAMP_CFG][CLAMP_EDGE_BIT] ? hs_rise : hs_fall)) begin
      cp_cnt_r <= clamp_width(cfg_r[ADDR_CLAMP_CFG][CLAMP_WIDTH_LSB +: 2]);
    end else if (cp_cnt_r != 4'h0) begin
      cp_cnt_r <= cp_cnt_r - 4'h1;
    end
  end

  // Level sample pulse, kept inside the blanking window while clamp config bit 7 is clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sp_cnt_r <= 4'h0;
    end else if (!blank_act) begin
      sp_cnt_r <= 4'h0;
    end else if (blank_rise) begin
      sp_cnt_r <= 4'h1;
    end else if ((sp_cnt_r != 4'h0) && (sp_cnt_r <= 4'(SAMPLE_DELAY_CYC + SAMPLE_WIDTH_CYC))) begin
      sp_cnt_r <= sp_cnt_r + 4'h1;
    end
  end

  always_comb begin
    sample_nxt = 1'b0;
    if (cfg_r[ADDR_CLAMP_CFG][CLAMP_TO_SAMPLE_BIT]) begin
      sample_nxt = clamp_nxt; // RL10 RL11
    end else begin
      sample_nxt = blank_act && (sp_cnt_r > 4'(SAMPLE_DELAY_CYC))
                   && (sp_cnt_r <= 4'(SAMPLE_DELAY_CYC + SAMPLE_WIDTH_CYC)); // RL9
    end
  end

  // Standby only gates the analog side; registers survive
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      BACK_PORCH_CLAMP_PULSE_O <= 1'b0;
      LEVEL_SAMPLE_PULSE_O     <= 1'b0;
      ANALOG_ON_O              <= 1'b0;
    end else begin
      BACK_PORCH_CLAMP_PULSE_O <= clamp_nxt;
      LEVEL_SAMPLE_PULSE_O     <= sample_nxt;
      ANALOG_ON_O              <= !sync_r[8]; // RL16
    end
  end

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_byte_end(vpi_state_type st);
    byte_done && (state_r == st);
  endsequence

  a_addr_ack: assert property (s_byte_end(ST_ADDR) ##0 addr_match |=> SDA_OE_O && state_r == ST_ACK_ADDR) // RL17
    else $error("own address not acknowledged");
  a_foreign_skip: assert property (s_byte_end(ST_ADDR) ##0 !addr_match |=> !SDA_OE_O && state_r == ST_SKIP) // RL17
    else $error("foreign address acknowledged");
  a_data_commit: assert property (wr_en |=> cfg_r[$past(reg_addr_r[3:0])] // RL24
                                  == ($past(shift_r) & $past(reg_mask(reg_addr_r))))
    else $error("data byte not latched");
  a_unmapped_keep: assert property (s_byte_end(ST_DATA) ##0 !reg_known(reg_addr_r) // RL25
                                    |=> $stable(cfg_r) && SDA_OE_O)
    else $error("unmapped write changed registers");
  a_pair_return: assert property (state_r == ST_ACK_DATA && scl_fall && !start_cond && !stop_cond // RL20
                                  |=> state_r == ST_REG && !SDA_OE_O)
    else $error("no return to register byte");
  a_no_readback: assert property (SDA_OE_O |-> !SDA_O && state_r inside {ST_ACK_ADDR, ST_ACK_REG, ST_ACK_DATA}) // RL18
    else $error("pin driven outside acknowledge");
  a_blank_force: assert property (blank_act |=> SRC_RED_O == SRC_INFRA && SRC_GREEN_O == SRC_INFRA // RL8
                                  && SRC_BLUE_O == SRC_INFRA)
    else $error("blanking did not force infra-black");
  a_overlay_bits: assert property (!blank_act && sync_r[5] && !grey_pat // RL5
                                   |=> SRC_RED_O == ($past(sync_r[2]) ? SRC_OSD : SRC_BRIGHT))
    else $error("overlay source wrong");
  a_common_target: assert property (ac_mode |=> COMMON_TARGET_O // RL9
                                    && TARGET_GREEN_O == $past(cfg_r[ADDR_COMMON_DC]))
    else $error("common target not used");
  a_sample_route: assert property (cfg_r[ADDR_CLAMP_CFG][CLAMP_TO_SAMPLE_BIT] // RL10
                                   ##1 cfg_r[ADDR_CLAMP_CFG][CLAMP_TO_SAMPLE_BIT]
                                   |-> LEVEL_SAMPLE_PULSE_O == BACK_PORCH_CLAMP_PULSE_O)
    else $error("clamp pulse not routed");
  a_sample_inside: assert property (LEVEL_SAMPLE_PULSE_O && !cfg_r[ADDR_CLAMP_CFG][CLAMP_TO_SAMPLE_BIT] // RL9
                                    && !$past(cfg_r[ADDR_CLAMP_CFG][CLAMP_TO_SAMPLE_BIT]) |-> $past(blank_act))
    else $error("sample pulse outside blanking");
  a_standby: assert property (sync_r[8] |=> !ANALOG_ON_O) // RL16
    else $error("analog left on in standby");

endmodule // vpi_control
`default_nettype wire

//--- tb/vpi_host.sv
// Serial bus host model that writes register pairs
`timescale 1ns/100ps
`default_nettype none
module vpi_host (
  // Clock
  input  wire logic clk_i,
  // Bus wires
  output logic      scl_o,
  output logic      sda_pull_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Data moves mid low phase, read at end of high phase
  task automatic put_bit(input logic b, output logic seen);
    sda_pull_o <= ~b;
    repeat (2) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    seen = sda_i;
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  // Long release first, so a late acknowledge never fakes a stop
  task automatic start_cond;
    sda_pull_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_pull_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic stop_cond;
    sda_pull_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_pull_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Write only, never a read byte
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule // vpi_host
`default_nettype wire

//--- tb/video_preamp_i2c_control_bench.sv
// Self-checking bench for the video preamp serial control block
`timescale 1ns/100ps
`default_nettype none
module video_preamp_i2c_control_bench;
  import vpi_pkg::*;
  logic        ref_clk, rstn, scl, sda_pull, sda_oe, sda_o, sda_w, ack;
  logic        fb, blank_in, ovr, ovg, ovb, hs, plow, inclamp, comt, back_porch_clamp_pulse, lsp, sclip, aon;
  vpi_src_type sr, sg, sb;
  logic [7:0]  tr, tg, tb, bri, dr, dg, db, lr, lg, lb, m;
  logic [3:0]  cdc, osl;
  logic [31:0] rnd;
  int          fail_count, checks, cnt_cp, cnt_sp;
  int          exp_reg [16];
  // Open drain wire with pull-up
  assign sda_w = !(sda_pull || (sda_oe && !sda_o));
  vpi_host u_host (.clk_i(ref_clk), .scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_w));
  vpi_control u_dut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .FAST_BLANK_IN_I(fb), .BLANK_IN_I(blank_in), .OVERLAY_RED_IN_I(ovr),
    .OVERLAY_GREEN_IN_I(ovg), .OVERLAY_BLUE_IN_I(ovb), .HSYNC_I(hs), .POWER_LOW_I(plow),
    .SRC_RED_O(sr), .SRC_GREEN_O(sg), .SRC_BLUE_O(sb), .INPUT_TO_CLAMP_O(inclamp),
    .TARGET_RED_O(tr), .TARGET_GREEN_O(tg), .TARGET_BLUE_O(tb), .COMMON_TARGET_O(comt),
    .BACK_PORCH_CLAMP_PULSE_O(back_porch_clamp_pulse), .LEVEL_SAMPLE_PULSE_O(lsp), .BRIGHTNESS_SETTING_O(bri),
    .DRIVE_RED_O(dr), .DRIVE_GREEN_O(dg), .DRIVE_BLUE_O(db), .COMMON_DC_O(cdc), .OSD_LEVEL_O(osl),
    .LEVEL_RED_O(lr), .LEVEL_GREEN_O(lg), .LEVEL_BLUE_O(lb), .SYNC_CLIP_O(sclip), .ANALOG_ON_O(aon));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic open_dev;
    u_host.start_cond();
    u_host.send_byte(8'hdc, ack);
    check("addr ack", {7'h0, ack}, 8'h01);
  endtask
  task automatic pair(input logic [7:0] a, input logic [7:0] d);
    u_host.send_byte(a, ack);
    check("reg ack", {7'h0, ack}, 8'h01);
    u_host.send_byte(d, ack);
    check("data ack", {7'h0, ack}, 8'h01);
    if (a >= 8'h02 && a <= 8'h0c) exp_reg[a] = (a == 8'h06 || a == 8'h07) ? d & 8'h0f : d;
  endtask
  task automatic cmp_regs;
    check("bright", bri, exp_reg[2][7:0]);
    check("drive r", dr, exp_reg[3][7:0]);
    check("drive g", dg, exp_reg[4][7:0]);
    check("drive b", db, exp_reg[5][7:0]);
    check("common dc", {4'h0, cdc}, exp_reg[6][7:0]);
    check("osd level", {4'h0, osl}, exp_reg[7][7:0]);
    check("level r", lr, exp_reg[10][7:0]);
    check("level g", lg, exp_reg[11][7:0]);
    check("level b", lb, exp_reg[12][7:0]);
    check("sync clip", {7'h0, sclip}, {7'h0, exp_reg[9][7]});
  endtask
  // Priority blank, grey, overlay, picture
  function automatic logic [7:0] exp_src(input logic ov);
    if (blank_in ^ m[0]) return 8'd5;
    if (fb && ovr && !ovg && ovb && m[5]) return 8'd3;
    if (fb && ovr && !ovg && ovb && m[6]) return 8'd4;
    if (fb) return ov ? 8'd2 : 8'd1;
    return 8'd0;
  endfunction
  // Count pulse cycles after a clamp config write and a blank or sync edge
  task automatic pulse_run(input logic [7:0] cfg);
    open_dev();
    pair(ADDR_CLAMP_CFG, cfg);
    u_host.stop_cond();
    blank_in <= cfg[0];
    hs <= !cfg[0];
    cnt_cp = 0;
    cnt_sp = 0;
    repeat (14) begin
      @(posedge ref_clk);
      cnt_cp += back_porch_clamp_pulse;
      cnt_sp += lsp;
    end
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    fb = 1'b0;
    blank_in = 1'b0;
    ovr = 1'b0;
    ovg = 1'b0;
    ovb = 1'b0;
    hs = 1'b0;
    plow = 1'b0;
    rnd = 32'h8dee;
    fail_count = 0;
    checks = 0;
    foreach (exp_reg[i]) exp_reg[i] = (i >= 3 && i <= 5) ? 8'hb4 : 0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    cmp_regs();
    check("analog on", {7'h0, aon}, 8'h01);
    // Foreign address and read direction are ignored
    for (int i = 0; i < 2; i++) begin
      u_host.start_cond();
      u_host.send_byte(i ? 8'hdd : 8'hde, ack);
      check("no ack", {7'h0, ack}, 8'h00);
      u_host.send_byte(8'h02, ack);
      u_host.send_byte(8'h55, ack);
      u_host.stop_cond();
    end
    cmp_regs();
    // Addresses 0 to 15 in one transfer, unmapped ones ignored
    open_dev();
    for (int a = 0; a < 16; a++) begin
      rnd = lfsr(rnd);
      pair(a[7:0], rnd[7:0]);
    end
    u_host.stop_cond();
    cmp_regs();
    for (int i = 0; i < 20; i++) begin
      rnd = lfsr(rnd);
      m = (i == 0) ? 8'h1c : (i == 1) ? 8'h08 : rnd[15:8];
      open_dev();
      pair(ADDR_MODE_CTRL, m);
      u_host.stop_cond();
      fb <= rnd[16];
      blank_in <= rnd[17];
      ovr <= rnd[18] | rnd[3];
      ovg <= rnd[19] & rnd[4];
      ovb <= rnd[20] | rnd[5];
      repeat (5) @(posedge ref_clk);
      check("src r", {5'h0, sr}, exp_src(ovr));
      check("src g", {5'h0, sg}, exp_src(ovg));
      check("src b", {5'h0, sb}, exp_src(ovb));
      check("in clamp", {7'h0, inclamp}, {7'h0, fb});
      check("common", {7'h0, comt}, {7'h0, &m[4:2]});
      check("tgt r", tr, &m[4:2] ? exp_reg[6][7:0] : exp_reg[10][7:0]);
      check("tgt g", tg, &m[4:2] ? exp_reg[6][7:0] : exp_reg[11][7:0]);
      check("tgt b", tb, &m[4:2] ? exp_reg[6][7:0] : exp_reg[12][7:0]);
      cmp_regs();
    end
    // Standby keeps the serial side alive
    plow <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("standby", {7'h0, aon}, 8'h00);
    open_dev();
    pair(ADDR_MODE_CTRL, 8'h04);
    pair(ADDR_CLAMP_CFG, 8'h90);
    pair(ADDR_BRIGHTNESS, 8'h00);
    u_host.stop_cond();
    m = 8'h04;
    cmp_regs();
    plow <= 1'b0; blank_in <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      hs <= ~hs;
      repeat (5) @(posedge ref_clk);
      check("clamp pulse", {7'h0, back_porch_clamp_pulse}, {7'h0, hs});
      check("sample pulse", {7'h0, lsp}, {7'h0, hs});
    end
    // Clamp from blanking rise, sample pulse inside the window
    pulse_run(8'h01);
    check("clamp blank", cnt_cp[7:0], 8'(CLAMP_W0_CYC));
    check("sample width", cnt_sp[7:0], 8'(SAMPLE_WIDTH_CYC));
    check("src blank", {5'h0, sr}, exp_src(ovr));
    // Clamp from sync leading edge, widest setting, no sample outside blanking
    pulse_run(8'h0e);
    check("clamp hsync", cnt_cp[7:0], 8'(CLAMP_W3_CYC));
    check("no sample", cnt_sp[7:0], 8'h00);
    check("analog back", {7'h0, aon}, 8'h01);
    summarize();
  end
endmodule // video_preamp_i2c_control_bench
`default_nettype wire
